// File: logic/pdmc_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - nine operating modes exist after reset, eight save power
// - all modes but active high-speed count as power-down
// - high-speed active: cpu and peripherals on full system clock
// - medium-speed active: cpu and peripherals on divided system clock
// - subactive: cpu runs on subclock, decoder on subclock
// - high-speed sleep: cpu halted, peripherals on system clock
// - medium-speed sleep: peripherals at 1/64, 1/32, 1/16 or 1/8
// - subsleep: cpu halted, timers, watchdog, serial, decoder on subclock
// - watch: only timer A base, timers F and G, decoder run
// - standby: everything halted except the decoder
// - module standby halts each peripheral software selected
// - five control flags qualify transitions, five condition codes
// - wake group one: timers A F G, int zero, wake pins
// - a pending request alone does not change mode
// - at least 8 standby states on wake from watch or standby
// - watch mode ignores non-wake external interrupts
module pdmc_power_ctrl (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic intAccepted,
  input wire logic [7:0] wake_pin_interrupts,
  input wire logic external_int_zero,
  input wire logic [4:1] extIntOther,
  input wire logic tmrAIrq,
  input wire logic tmrFIrq,
  input wire logic tmrGIrq,
  input wire logic otherIrq,
  output logic [4:1] extIntGated,
  output logic cpuRun,
  output logic cpuOnSubclk,
  output logic sysOscRun,
  output logic periphOnSubclk,
  output logic [1:0] periphDivSel,
  output logic periphDivEn,
  output logic [9:0] modRun,
  output logic powerDown,
  output logic [3:0] modeCode
);
  //////////////////////////////////////////////////////////////////////////
  // registers
  logic low_speed_on_flag;
  logic medium_speed_on_flag;
  logic software_standby_flag;
  logic timer_a_mode_bit3;
  logic direct_transfer_flag;
  logic [4:0] ctrl_q;
  logic [2:0] standby_timer_select;
  logic [1:0] div_q;
  logic [9:0] modStby_q;
  logic respPend_q;
  logic [31:0] rdata_q;
  pdmc_pkg::pdmc_mode_type mode_q, mode_d, wakeTarget_q;
  logic wakeReq_q;

  // control flag decode
  assign low_speed_on_flag = ctrl_q[pdmc_pkg::LsonBit];
  assign medium_speed_on_flag = ctrl_q[pdmc_pkg::MsonBit];
  assign software_standby_flag = ctrl_q[pdmc_pkg::SsbyBit];
  assign timer_a_mode_bit3 = ctrl_q[pdmc_pkg::Tma3Bit];
  assign direct_transfer_flag = ctrl_q[pdmc_pkg::DtonBit];

  //////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle on every access
  logic access;
  logic wrStrobe;
  logic selCtrl, selStby, selMod, selStat;
  logic sleepCmd;
  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~respPend_q;
  assign wrStrobe = avs_write & respPend_q;
  assign selCtrl = (avs_address == pdmc_pkg::RegCtrlOff);
  assign selStby = (avs_address == pdmc_pkg::RegStbyOff);
  assign selMod = (avs_address == pdmc_pkg::RegModStbyOff);
  assign selStat = (avs_address == pdmc_pkg::RegStatOff);
  assign sleepCmd = wrStrobe & selCtrl & avs_writedata[pdmc_pkg::SleepBit];
  assign avs_readdata = rdata_q;

  // read mux, unmapped reads give zero
  logic [31:0] rdMux;
  assign rdMux = selCtrl ? {27'h0, ctrl_q} :
                 selStby ? {25'h0, standby_timer_select, 2'h0, div_q} :
                 selMod ? {22'h0, modStby_q} :
                 selStat ? {27'h0, powerDown, modeCode} : 32'h0;

  // wait-state tracker and read data register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      respPend_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      respPend_q <= access & ~respPend_q;
      rdata_q <= rdMux;
    end
  end

  // software-written configuration
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= pdmc_pkg::CtrlReset;
      standby_timer_select <= pdmc_pkg::StsReset;
      div_q <= pdmc_pkg::DivReset;
      modStby_q <= pdmc_pkg::ModStbyReset;
    end else if (wrStrobe) begin
      if (selCtrl) ctrl_q <= avs_writedata[4:0];
      if (selStby) begin
        standby_timer_select <= avs_writedata[pdmc_pkg::StsMsb:
                                              pdmc_pkg::StsLsb];
        div_q <= avs_writedata[pdmc_pkg::DivMsb:pdmc_pkg::DivLsb];
      end
      if (selMod) modStby_q <= avs_writedata[9:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wake qualification
  logic group1, group3, wakeSrc;
  assign group1 = tmrAIrq | tmrFIrq | tmrGIrq | external_int_zero |
                  (|wake_pin_interrupts);
  assign group3 = group1 | (|extIntOther) | otherIrq;
  // watch and standby accept only group one
  assign wakeSrc = ((mode_q == pdmc_pkg::ModeWatch) ||
                    (mode_q == pdmc_pkg::ModeStandby)) ? group1 : group3;
  // non-wake external lines are masked in watch mode
  assign extIntGated = (mode_q == pdmc_pkg::ModeWatch) ? 4'h0 :
                       extIntOther;

  // condition codes a..e from the five flags
  logic condA, condB, condC, condD, condE;
  assign condA = !low_speed_on_flag && !medium_speed_on_flag &&
                 !software_standby_flag && !direct_transfer_flag;
  assign condB = !low_speed_on_flag && medium_speed_on_flag &&
                 !software_standby_flag && !direct_transfer_flag;
  assign condC = low_speed_on_flag && !software_standby_flag &&
                 timer_a_mode_bit3 && !direct_transfer_flag;
  assign condD = !low_speed_on_flag && software_standby_flag &&
                 !timer_a_mode_bit3 && !direct_transfer_flag;
  assign condE = software_standby_flag && timer_a_mode_bit3 &&
                 !direct_transfer_flag;
  // target when sleep is executed; direct transfers go straight to active
  pdmc_pkg::pdmc_mode_type sleepTarget;
  logic activeLike;
  assign activeLike = (mode_q == pdmc_pkg::ModeActHigh) ||
                      (mode_q == pdmc_pkg::ModeActMed);
  assign sleepTarget = direct_transfer_flag ?
      (medium_speed_on_flag ? pdmc_pkg::ModeActMed : pdmc_pkg::ModeActHigh) :
      condE ? pdmc_pkg::ModeWatch :
      condD ? pdmc_pkg::ModeStandby :
      condC ? pdmc_pkg::ModeSubSleep :
      condB ? pdmc_pkg::ModeSleepMed :
      condA ? pdmc_pkg::ModeSleepHigh : mode_q;

  //////////////////////////////////////////////////////////////////////////
  // standby counter for oscillator restart
  logic stbyStart, stbyDone;
  assign stbyStart = wakeReq_q && (mode_q != pdmc_pkg::ModeWake);
  pdmc_stby_counter u_stby (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(stbyStart),
    .sel(standby_timer_select),
    .done(stbyDone)
  );

  // next mode; a request alone waits for acceptance
  logic oscStopped;
  assign oscStopped = (mode_q == pdmc_pkg::ModeWatch) ||
                      (mode_q == pdmc_pkg::ModeStandby) ||
                      (mode_q == pdmc_pkg::ModeSubSleep) ||
                      (mode_q == pdmc_pkg::ModeSubAct);
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      pdmc_pkg::ModeActHigh, pdmc_pkg::ModeActMed,
      pdmc_pkg::ModeSubAct: begin
        if (sleepCmd) mode_d = sleepTarget;
      end
      pdmc_pkg::ModeWake: begin
        if (stbyDone) mode_d = wakeTarget_q;
      end
      default: begin
        if (wakeSrc && intAccepted) begin
          mode_d = (mode_q == pdmc_pkg::ModeSubSleep) ?
                   pdmc_pkg::ModeSubAct : wakeTarget_q;
        end
      end
    endcase
    // leaving watch or standby goes through the standby wait
    if (stbyStart) mode_d = pdmc_pkg::ModeWake;
  end

  // mode register and wake bookkeeping
  logic leaveOscOff;
  assign leaveOscOff = oscStopped && (mode_q != pdmc_pkg::ModeSubAct) &&
                       (mode_q != pdmc_pkg::ModeSubSleep) &&
                       wakeSrc && intAccepted;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= pdmc_pkg::ModeActHigh;
      wakeTarget_q <= pdmc_pkg::ModeActHigh;
      wakeReq_q <= 1'b0;
    end else begin
      mode_q <= leaveOscOff ? mode_q : mode_d;
      wakeReq_q <= leaveOscOff;
      if (activeLike && sleepCmd)
        wakeTarget_q <= mode_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock and run outputs per mode
  logic inMed, inSub;
  assign inMed = (mode_q == pdmc_pkg::ModeActMed) ||
                 (mode_q == pdmc_pkg::ModeSleepMed);
  assign inSub = (mode_q == pdmc_pkg::ModeSubAct) ||
                 (mode_q == pdmc_pkg::ModeSubSleep) ||
                 (mode_q == pdmc_pkg::ModeWatch);
  assign cpuRun = activeLike || (mode_q == pdmc_pkg::ModeSubAct);
  assign cpuOnSubclk = (mode_q == pdmc_pkg::ModeSubAct);
  assign sysOscRun = !oscStopped;
  assign periphOnSubclk = inSub;
  assign periphDivEn = inMed;
  assign periphDivSel = div_q;
  assign powerDown = (mode_q != pdmc_pkg::ModeActHigh);
  assign modeCode = 4'(mode_q);

  // per-module run enables
  genvar g;
  generate
    for (g = 0; g < pdmc_pkg::NumMods; g++) begin : gMod
      logic modeOk;
      if (g == pdmc_pkg::ModDec) begin : gDec
        assign modeOk = 1'b1;
      end else if (g == pdmc_pkg::ModTmrA || g == pdmc_pkg::ModTmrF ||
                   g == pdmc_pkg::ModTmrG) begin : gWatch
        assign modeOk = (mode_q != pdmc_pkg::ModeStandby) &&
                        (mode_q != pdmc_pkg::ModeWake);
      end else if (g == pdmc_pkg::ModAdc) begin : gAdc
        assign modeOk = !inSub && !oscStopped &&
                        (mode_q != pdmc_pkg::ModeWake);
      end else begin : gSub
        assign modeOk = !oscStopped ||
                        (mode_q == pdmc_pkg::ModeSubAct) ||
                        (mode_q == pdmc_pkg::ModeSubSleep);
      end
      assign modRun[g] = modeOk && !modStby_q[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // checks
  // all checks run on the system clock and sleep during reset
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // entry into the standby wait, then the wait itself
  sequence wake_enter_s;
    $rose(mode_q == pdmc_pkg::ModeWake);
  endsequence
  sequence wake_hold_s;
    (mode_q == pdmc_pkg::ModeWake) [*8];
  endsequence
  property wake_gap_p;
    wake_enter_s |-> wake_hold_s;
  endproperty
  stby_min_wait_a: assert property (wake_gap_p)
    else $error("standby wait shorter than 8 states");
  watch_mask_a: assert property (
    (mode_q == pdmc_pkg::ModeWatch) |-> (extIntGated == 4'h0))
    else $error("external interrupt passed in watch mode");
  // a standby exit needs an accepted wake, already in flight or new
  no_accept_stay_a: assert property (
    (mode_q == pdmc_pkg::ModeStandby) && !intAccepted && !wakeReq_q |=>
      (mode_q == pdmc_pkg::ModeStandby))
    else $error("mode left without acceptance");
  cpu_standby_a: assert property (
    (mode_q == pdmc_pkg::ModeStandby) |-> !cpuRun && (modRun == 10'h200))
    else $error("activity in standby");
  mod_stby_a: assert property (
    $past(wrStrobe && selMod) |->
      ((modRun & $past(avs_writedata[9:0])) == 10'h000))
    else $error("selected module still runs");
  // power-down is anything short of a full-speed cpu on the system clock
  power_down_a: assert property (
    powerDown == !(cpuRun && sysOscRun && !cpuOnSubclk && !periphDivEn))
    else $error("power-down flag mismatch");
  sub_cpu_a: assert property (
    cpuOnSubclk |-> cpuRun && !sysOscRun)
    else $error("subactive clocking wrong");
  med_div_a: assert property (
    (mode_q == pdmc_pkg::ModeSleepMed) |-> periphDivEn && !cpuRun)
    else $error("medium sleep clocking wrong");
endmodule : pdmc_power_ctrl
`default_nettype wire

// File: common/pdmc_pkg.sv
package pdmc_pkg;
  // register byte offsets
  localparam logic [3:0] RegCtrlOff = 4'h0; // control flags
  localparam logic [3:0] RegStbyOff = 4'h4; // standby timer and divider
  localparam logic [3:0] RegModStbyOff = 4'h8; // per-module standby
  localparam logic [3:0] RegStatOff = 4'hc; // mode and run status
  // control register field positions
  localparam int LsonBit = 0;
  localparam int MsonBit = 1;
  localparam int SsbyBit = 2;
  localparam int Tma3Bit = 3;
  localparam int DtonBit = 4;
  localparam int SleepBit = 5;  // write 1: execute sleep instruction
  // standby register fields
  localparam int StsLsb = 4;
  localparam int StsMsb = 6;
  localparam int DivLsb = 0;
  localparam int DivMsb = 1;
  // reset values
  localparam logic [4:0] CtrlReset = 5'h00;
  localparam logic [2:0] StsReset = 3'h0;
  localparam logic [1:0] DivReset = 2'h0;
  localparam logic [9:0] ModStbyReset = 10'h000;
  // module standby bit positions, one per peripheral
  localparam int NumMods = 10;
  localparam int ModTmrA = 0;
  localparam int ModTmrC = 1;
  localparam int ModTmrF = 2;
  localparam int ModTmrG = 3;
  localparam int ModWdt = 4;
  localparam int ModSer1 = 5;
  localparam int ModSer31 = 6;
  localparam int ModSer32 = 7;
  localparam int ModAdc = 8;
  localparam int ModDec = 9;
  // standby time in states: 8 up to 16384
  localparam int StbyMinStates = 8;
  localparam int StbyMaxStates = 16384;
  // operating modes
  typedef enum logic [3:0] {
    ModeActHigh, ModeActMed, ModeSubAct, ModeSleepHigh, ModeSleepMed,
    ModeSubSleep, ModeWatch, ModeStandby, ModeWake
  } pdmc_mode_type;
endpackage : pdmc_pkg

// File: logic/pdmc_stby_counter.sv
`timescale 1ns/1ps
`default_nettype none
// counts the programmed standby states before release
module pdmc_stby_counter (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [2:0] sel,
  output logic done
);
  logic [14:0] count_q;
  logic [14:0] count_d;
  logic [14:0] limit;
  logic running_q;
  // select of 2^(sel+3) states: 8 .. 512, sel 7 gives 16384
  assign limit = (sel == 3'h7) ? 15'(pdmc_pkg::StbyMaxStates - 1) :
                 15'((15'h0008 << sel) - 15'h0001);
  assign done = running_q && (count_q == limit);
  assign count_d = start ? 15'h0000 : (count_q + 15'h0001);
  // counter runs only while waiting
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= 15'h0000;
      running_q <= 1'b0;
    end else if (start || (running_q && !done)) begin
      count_q <= count_d;
      running_q <= 1'b1;
    end else begin
      running_q <= 1'b0;
    end
  end
endmodule : pdmc_stby_counter
`default_nettype wire

// File: tb/tb_power_down_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_power_down_mode_control;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, intAccepted;
  logic [3:0] avs_address, extIntOther, extIntGated, modeCode;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] wake_pin_interrupts;
  logic external_int_zero, tmrAIrq, tmrFIrq, tmrGIrq, otherIrq, cpuRun;
  logic cpuOnSubclk, sysOscRun, periphOnSubclk, periphDivEn, powerDown;
  logic [1:0] periphDivSel;
  logic [9:0] modRun;
  int error_cnt, tests_run, n;
  //////////////////////////////////////////////////////////////////////////
  pdmc_power_ctrl pdmc_power_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .intAccepted(intAccepted),
    .wake_pin_interrupts(wake_pin_interrupts),
    .external_int_zero(external_int_zero), .extIntOther(extIntOther),
    .tmrAIrq(tmrAIrq), .tmrFIrq(tmrFIrq), .tmrGIrq(tmrGIrq),
    .otherIrq(otherIrq), .extIntGated(extIntGated), .cpuRun(cpuRun),
    .cpuOnSubclk(cpuOnSubclk), .sysOscRun(sysOscRun),
    .periphOnSubclk(periphOnSubclk), .periphDivSel(periphDivSel),
    .periphDivEn(periphDivEn), .modRun(modRun), .powerDown(powerDown),
    .modeCode(modeCode));
  // 20 MHz system clock
  always #25 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  // mode compare
  task automatic chk_mode(input logic [3:0] exp);
    tests_run++;
    if (modeCode !== exp) begin
      error_cnt++;
      $display("BAD %0t mode %h expected %h", $time, modeCode, exp);
    end
  endtask : chk_mode
  // hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 50) chk(32'h0000_dead, 32'h0);
    // let the completing edge settle before anyone looks at outputs
    @(negedge sys_clk);
  endtask : bus
  // flags are written first; the sleep strobe acts on the stored flags
  task automatic do_sleep(input logic [4:0] f);
    bus(1'b1, pdmc_pkg::RegCtrlOff, {27'h0, f});
    bus(1'b1, pdmc_pkg::RegCtrlOff, {26'h1, f});
  endtask : do_sleep
  task automatic rst;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : rst
  // raise one source with acceptance for two cycles
  task automatic fire(input int s);
    @(posedge sys_clk);
    otherIrq <= (s == 0);
    tmrAIrq <= (s == 1);
    wake_pin_interrupts <= (s == 2) ? 8'h08 : 8'h00;
    external_int_zero <= (s == 3);
    intAccepted <= 1'b1;
    repeat (2) @(posedge sys_clk);
    {otherIrq, tmrAIrq, external_int_zero, intAccepted} <= 4'h0;
    wake_pin_interrupts <= 8'h00;
  endtask : fire
  task automatic wait_mode(input logic [3:0] m);
    n = 2;
    while (modeCode !== m && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk_mode(m);
  endtask : wait_mode
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_mode(pdmc_pkg::ModeActHigh);
    chk({powerDown, cpuRun, sysOscRun}, 32'h3);
    chk(modRun, 32'h3ff);
    for (int a = 0; a < 16; a += 2) begin
      bus(1'b0, a[3:0], 32'h0);
      chk(rd, (a == 12) ? 32'h0 : 32'h0);
    end
  endtask : t_reset
  task automatic t_regs;
    bus(1'b1, pdmc_pkg::RegCtrlOff, 32'h1f);
    bus(1'b0, pdmc_pkg::RegCtrlOff, 32'h0);
    chk(rd, 32'h1f);
    bus(1'b1, pdmc_pkg::RegStbyOff, 32'h73);
    bus(1'b0, pdmc_pkg::RegStbyOff, 32'h0);
    chk(rd, 32'h73);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs
  task automatic t_sleep_high;
    extIntOther <= 4'ha;
    do_sleep(5'h00);
    chk_mode(pdmc_pkg::ModeSleepHigh);
    chk({powerDown, cpuRun, sysOscRun, extIntGated}, 32'h5a);
    @(posedge sys_clk);
    otherIrq <= 1'b1;
    repeat (4) @(posedge sys_clk);
    otherIrq <= 1'b0;
    chk_mode(pdmc_pkg::ModeSleepHigh);
    fire(0);
    wait_mode(pdmc_pkg::ModeActHigh);
  endtask : t_sleep_high
  task automatic t_sleep_med;
    do_sleep(5'h12);
    chk_mode(pdmc_pkg::ModeActMed);
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, pdmc_pkg::RegStbyOff, d);
      do_sleep(5'h02);
      chk_mode(pdmc_pkg::ModeSleepMed);
      chk({cpuRun, periphDivEn, periphDivSel}, 4 + d);
      fire(0);
      wait_mode(pdmc_pkg::ModeActMed);
      chk({cpuRun, periphDivEn, powerDown}, 32'h7);
    end
  endtask : t_sleep_med
  task automatic t_watch;
    extIntOther <= 4'hf;
    do_sleep(5'h0c);
    chk_mode(pdmc_pkg::ModeWatch);
    chk({sysOscRun, cpuRun, extIntGated}, 32'h0);
    chk(modRun, 32'h20d);
    bus(1'b0, pdmc_pkg::RegStatOff, 32'h0);
    chk(rd, 32'h10 | pdmc_pkg::ModeWatch);
    fire(0);
    repeat (4) @(posedge sys_clk);
    chk_mode(pdmc_pkg::ModeWatch);
    fire(1);
    wait_mode(pdmc_pkg::ModeActHigh);
    chk(n >= pdmc_pkg::StbyMinStates, 32'h1);
  endtask : t_watch
  task automatic t_standby;
    bus(1'b1, pdmc_pkg::RegStbyOff, 32'h10);
    do_sleep(5'h04);
    chk_mode(pdmc_pkg::ModeStandby);
    chk({cpuRun, sysOscRun, modRun}, 32'h200);
    fire(3);
    wait_mode(pdmc_pkg::ModeActHigh);
    chk(n >= 16, 32'h1);
  endtask : t_standby
  task automatic t_subsleep;
    do_sleep(5'h09);
    chk_mode(pdmc_pkg::ModeSubSleep);
    chk({cpuRun, periphOnSubclk, modRun}, 32'h6ff);
    fire(2);
    wait_mode(pdmc_pkg::ModeSubAct);
    chk({cpuRun, cpuOnSubclk, sysOscRun}, 32'h6);
  endtask : t_subsleep
  task automatic t_modstby;
    bus(1'b1, pdmc_pkg::RegModStbyOff, 32'h105);
    bus(1'b0, pdmc_pkg::RegModStbyOff, 32'h0);
    chk(rd, 32'h105);
    chk(modRun, 32'h2fa);
  endtask : t_modstby
  //////////////////////////////////////////////////////////////////////////
  // main sequence, t_regs follows t_reset, each other scenario from a fresh reset
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {avs_read, avs_write, intAccepted, otherIrq} = 4'h0;
    {external_int_zero, tmrAIrq, tmrFIrq, tmrGIrq} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    wake_pin_interrupts = 8'h00;
    extIntOther = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    rst();
    t_reset();
    t_regs();
    rst();
    t_sleep_high();
    rst();
    t_sleep_med();
    rst();
    t_watch();
    rst();
    t_standby();
    rst();
    t_subsleep();
    rst();
    t_modstby();
    end_sim();
  end
  // watchdog against a hung handshake or mode wait
  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
endmodule : tb_power_down_mode_control
`default_nettype wire
